//--- rtl/fsb_burst_read.sv
// burst read engine with its configuration register, facing the flash bus pins
// assumes the host drives select, enable, strobe and address on ref_clk edges,
// and the array returns the addressed line combinationally from lineAddr
`timescale 1ns/100ps
`default_nettype none

module fsb_burst_read
  import fsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmdReset,
  input wire logic chipSelect_n,
  input wire logic outputEnable_n,
  input wire logic address_valid_strobe_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic cfgWrite,
  input wire logic [15:0] cfgWriteData,
  output logic [15:0] cfgReadData,
  output logic [LINE_ADDR_W-1:0] lineAddr,
  input wire logic [LINE_W-1:0] lineData,
  output logic [WORD_W-1:0] data_pins_out,
  output logic data_pins_oe,
  output logic driveHalf,
  output logic readyFlag,
  output logic readyFlag_oe
);

  typedef struct packed {
    logic [15:0] cfg;
    logic active;
    logic asyncRd;
    logic cont;
    logic [3:0] mask;
    logic [LINE_ADDR_W-1:0] lineAddr;
    logic [IDX_W-1:0] pushIdx;
    logic [4:0] pushLeft;
    logic [IDX_W-1:0] popIdx;
    logic [4:0] popLeft;
    logic [3:0] waitCnt;
    logic [WORD_W-1:0] dataOut;
    logic dataOe;
    logic rdyOut;
    logic rdyOe;
    logic drvHalf;
  } fsb_state_t;

  localparam fsb_state_t STATE_RESET = '{
    cfg: CFG_RESET,
    active: 1'b0,
    asyncRd: 1'b1,
    cont: 1'b1,
    mask: MASK_LINE,
    lineAddr: '0,
    pushIdx: '0,
    pushLeft: '0,
    popIdx: '0,
    popLeft: '0,
    waitCnt: '0,
    dataOut: '0,
    dataOe: 1'b0,
    rdyOut: 1'b0,
    rdyOe: 1'b0,
    drvHalf: 1'b0
  };

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // latency in cycles from the code; reserved codes clamp to the nearest legal one
  function automatic logic [3:0] latCycles(input logic [3:0] code);
    logic [3:0] c;
    c = code;
    if (c < LAT_CODE_MIN)
      c = LAT_CODE_MIN;
    if (c > LAT_CODE_MAX)
      c = LAT_CODE_MAX;
    return c + LAT_CODE_ADD;
  endfunction

  // next word index, staying inside the aligned group given by the mask
  function automatic logic [3:0] nextIdx(input logic [3:0] idx, input logic [3:0] mask);
    logic [3:0] inc;
    inc = idx + 4'h1;
    return (idx & ~mask) | (inc & mask);
  endfunction

  // one word out of the fetched line
  function automatic logic [WORD_W-1:0] lineWord(input logic [LINE_W-1:0] line,
                                                 input logic [3:0] idx);
    return line[idx*WORD_W +: WORD_W];
  endfunction

  fsb_state_t s_q;
  fsb_state_t s_d;
  logic [3:0] latency;
  logic [2:0] lenCode;
  logic capture;
  logic pushWant;
  logic pushReady;
  logic popWant;
  logic popValid;
  logic [WORD_W-1:0] popData;
  logic popGo;
  logic fifoFlush;
  logic readyNow;
  logic readyNext;
  logic readyLevel;

  ////////////////////////////////////////////////////////////////////////
  // word buffer between the line fetch and the pin stage; it stalls the fetch
  // side when full, so the fetch can run ahead of a host that pauses
  fsb_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .flush(fifoFlush),
    .inValid(pushWant),
    .inReady(pushReady),
    .inData(lineWord(lineData, s_q.pushIdx)),
    .outValid(popValid),
    .outReady(popWant),
    .outData(popData)
  );

  ////////////////////////////////////////////////////////////////////////
  // handshake terms of the current cycle
  assign latency = latCycles(s_q.cfg[LAT_HI:LAT_LO]);
  assign lenCode = s_q.cfg[LEN_HI:LEN_LO];
  assign capture = !chipSelect_n && !address_valid_strobe_n;
  assign fifoFlush = chipSelect_n || capture || cmdReset || !s_q.active;
  // fetch words only for a live sync burst with words still owed
  assign pushWant = s_q.active && !s_q.asyncRd && !fifoFlush
                    && (s_q.cont || s_q.pushLeft != '0);
  // a word leaves once latency has run out and the host enables the outputs
  assign popWant = s_q.active && !s_q.asyncRd && !fifoFlush && s_q.waitCnt == '0
                   && (s_q.cont || s_q.popLeft != '0) && !outputEnable_n;
  assign popGo = popWant && popValid;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_d = s_q;
    readyNow = 1'b0;
    readyNext = 1'b0;
    readyLevel = 1'b0;

    // writes are taken at any time, sync read mode or not
    if (cfgWrite)
      s_d.cfg = cfgWriteData;

    if (chipSelect_n || cmdReset)
    begin
      // deselect ends any burst; command reset keeps the configuration
      s_d.active = 1'b0;
      s_d.waitCnt = '0;
    end
    else if (capture)
    begin
      // new address: restart the fetch whatever was running
      s_d.active = 1'b1;
      s_d.asyncRd = s_q.cfg[MODE_BIT];
      s_d.lineAddr = address[ADDR_W-1:IDX_W];
      s_d.pushIdx = address[IDX_W-1:0];
      s_d.popIdx = address[IDX_W-1:0];
      s_d.waitCnt = latency - LAT_FIRST_OFS;
      case (lenCode)
        LEN_WRAP8:
        begin
          s_d.cont = 1'b0;
          s_d.mask = MASK_WRAP8;
          s_d.pushLeft = CNT_WRAP8;
          s_d.popLeft = CNT_WRAP8;
        end
        LEN_WRAP16:
        begin
          s_d.cont = 1'b0;
          s_d.mask = MASK_LINE;
          s_d.pushLeft = CNT_WRAP16;
          s_d.popLeft = CNT_WRAP16;
        end
        // reserved codes run as continuous
        default:
        begin
          s_d.cont = 1'b1;
          s_d.mask = MASK_LINE;
          s_d.pushLeft = '0;
          s_d.popLeft = '0;
        end
      endcase
    end
    else if (s_q.active)
    begin
      // fetch side walks the line; in a continuous burst it moves to the next line at its end
      if (pushWant && pushReady)
      begin
        s_d.pushIdx = nextIdx(s_q.pushIdx, s_q.mask);
        if (s_q.cont && s_q.pushIdx == IDX_LAST)
          s_d.lineAddr = s_q.lineAddr + 1'b1;
        if (!s_q.cont)
          s_d.pushLeft = s_q.pushLeft - 5'h01;
      end
      // pin side: one word per clock, with a fresh latency at a line crossing
      if (popGo)
      begin
        s_d.dataOut = popData;
        s_d.popIdx = nextIdx(s_q.popIdx, s_q.mask);
        if (!s_q.cont)
          s_d.popLeft = s_q.popLeft - 5'h01;
        if (s_q.cont && s_q.popIdx == IDX_LAST)
          s_d.waitCnt = latency - LAT_LINE_OFS;
      end
      else if (s_q.waitCnt != '0)
        s_d.waitCnt = s_q.waitCnt - 4'h1;
      // async read shows the word the address pins pick inside the line
      if (s_q.asyncRd)
        s_d.dataOut = lineWord(lineData, address[IDX_W-1:0]);
    end

    // ready with the data, or one cycle ahead of the next word
    readyNow = popGo;
    readyNext = s_d.active && !s_d.asyncRd && s_d.waitCnt == '0
                && (s_d.cont || s_d.popLeft != '0) && !capture;
    readyLevel = s_q.cfg[TIM_BIT] ? readyNow : readyNext;
    s_d.rdyOut = s_q.cfg[POL_BIT] ? readyLevel : !readyLevel;
    s_d.rdyOe = !chipSelect_n;
    s_d.dataOe = !chipSelect_n && !outputEnable_n;
    s_d.drvHalf = s_q.cfg[DRV_BIT];
  end

  // hardware reset restores every field, the configuration included
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      s_q <= STATE_RESET;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign cfgReadData = s_q.cfg;
  assign lineAddr = s_q.lineAddr;
  assign data_pins_out = s_q.dataOut;
  assign data_pins_oe = s_q.dataOe;
  assign driveHalf = s_q.drvHalf;
  assign readyFlag = s_q.rdyOut;
  assign readyFlag_oe = s_q.rdyOe;

endmodule

`default_nettype wire

//--- rtl/fsb_pkg.sv
// constants of the synchronous burst read engine and its configuration register
// assumes one bus clock shared with the host; array reads are combinational on a line

package fsb_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 26;
  localparam int IDX_W = 4;
  localparam int LINE_WORDS = 16;
  localparam int LINE_W = WORD_W * LINE_WORDS;
  localparam int LINE_ADDR_W = ADDR_W - IDX_W;
  localparam int FIFO_DEPTH = 8;

  // configuration register layout
  localparam logic [15:0] CFG_RESET = 16'hDF48;
  localparam int MODE_BIT = 15;
  localparam int LAT_HI = 14;
  localparam int LAT_LO = 11;
  localparam int POL_BIT = 10;
  localparam int TIM_BIT = 8;
  localparam int DRV_BIT = 7;
  localparam int LEN_HI = 2;
  localparam int LEN_LO = 0;

  // latency code decode
  localparam logic [3:0] LAT_CODE_MIN = 4'h1;
  localparam logic [3:0] LAT_CODE_MAX = 4'hD;
  localparam logic [3:0] LAT_CODE_ADD = 4'h2;
  localparam logic [3:0] LAT_FIRST_OFS = 4'h2;
  localparam logic [3:0] LAT_LINE_OFS = 4'h1;

  // burst length codes and counts
  localparam logic [2:0] LEN_CONT = 3'h0;
  localparam logic [2:0] LEN_WRAP8 = 3'h2;
  localparam logic [2:0] LEN_WRAP16 = 3'h3;
  localparam logic [4:0] CNT_WRAP8 = 5'h08;
  localparam logic [4:0] CNT_WRAP16 = 5'h10;
  localparam logic [3:0] MASK_WRAP8 = 4'h7;
  localparam logic [3:0] MASK_LINE = 4'hF;
  localparam logic [3:0] IDX_LAST = 4'hF;
endpackage

//--- rtl/fsb_fifo.sv
// word FIFO between the line fetch and the data pin stage
// assumes flush and both handshakes come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module fsb_fifo
  import fsb_pkg::*;
#(
  parameter int W = 16,
  parameter int DEPTH = 8
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } fsb_fifo_state_t;

  fsb_fifo_state_t s_q;
  fsb_fifo_state_t s_d;
  logic doPush;
  logic doPop;

  ////////////////////////////////////////////////////////////////////////
  // honest full and empty from the occupancy count
  assign inReady = (s_q.count != DEPTH[PW:0]);
  assign outValid = (s_q.count != '0);
  assign outData = s_q.mem[s_q.rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // pointer and count update; flush drops everything held
  always_comb
  begin
    s_d = s_q;
    if (flush)
    begin
      s_d.wrPtr = '0;
      s_d.rdPtr = '0;
      s_d.count = '0;
    end
    else
    begin
      if (doPush)
      begin
        s_d.mem[s_q.wrPtr] = inData;
        s_d.wrPtr = s_q.wrPtr + 1'b1;
      end
      if (doPop)
        s_d.rdPtr = s_q.rdPtr + 1'b1;
      if (doPush && !doPop)
        s_d.count = s_q.count + 1'b1;
      else if (doPop && !doPush)
        s_d.count = s_q.count - 1'b1;
    end
  end

  // storage is not cleared on reset, only the pointers and the count
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_q.wrPtr <= '0;
      s_q.rdPtr <= '0;
      s_q.count <= '0;
      s_q.mem <= s_d.mem;
    end
    else
      s_q <= s_d;
  end
endmodule

`default_nettype wire

//--- testbench/fsb_array_model.sv
// array model on the far side of the burst engine's line port
// assumes the engine presents a registered line index and reads back at once
`timescale 1ns/100ps
`default_nettype none
module fsb_array_model
  import fsb_pkg::*;
(
  input wire logic [LINE_ADDR_W-1:0] lineAddr,
  output logic [LINE_W-1:0] lineData
);
  // each word carries its own low address bits, so a misplaced word shows at once
  always_comb
    for (int i = 0; i < LINE_WORDS; i++)
      lineData[i*WORD_W +: WORD_W] = {lineAddr[11:0], 4'(i)};
endmodule
`default_nettype wire

//--- testbench/fsb_burst_read_assertions.sv
// checker for the burst read engine, watching only its ports
// assumes one clock and a synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module fsb_burst_read_assertions
  import fsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmdReset,
  input wire logic chipSelect_n,
  input wire logic outputEnable_n,
  input wire logic address_valid_strobe_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic cfgWrite,
  input wire logic [15:0] cfgWriteData,
  input wire logic [15:0] cfgReadData,
  input wire logic [LINE_ADDR_W-1:0] lineAddr,
  input wire logic [LINE_W-1:0] lineData,
  input wire logic [WORD_W-1:0] data_pins_out,
  input wire logic data_pins_oe,
  input wire logic driveHalf,
  input wire logic readyFlag,
  input wire logic readyFlag_oe
);
  logic [5:0] since_q;
  logic [3:0] startIdx_q;
  logic [15:0] firstWord_q;
  logic [4:0] latency;
  logic sync;
  ////////////////////////////////////////////////////////////////////////////////
  // latency in cycles; reserved codes clamp to the nearest legal figure
  always_comb
  begin
    latency = 5'(cfgReadData[14:11]) + 5'h02;
    if (cfgReadData[14:11] == 4'h0)
      latency = 5'h03;
    if (cfgReadData[14:11] > 4'hD)
      latency = 5'h0F;
  end
  assign sync = !cfgReadData[MODE_BIT] && !chipSelect_n;
  // edges since the strobe; saturates so a long idle never wraps into a false match
  always_ff @(posedge ref_clk)
    if (srst)
      since_q <= 6'h00;
    else if (!chipSelect_n && !address_valid_strobe_n)
      since_q <= 6'h01;
    else if (since_q != 6'h00 && since_q != 6'h3F)
      since_q <= since_q + 6'h01;
  // word index the burst starts from
  always_ff @(posedge ref_clk)
    if (!address_valid_strobe_n)
      startIdx_q <= address[3:0];
  // first word taken while the line just latched is on the port; a continuous
  // fetch may already have moved the line on by the time the word is shown
  always_ff @(posedge ref_clk)
    if (since_q == 6'h01)
      firstWord_q <= lineData[16*startIdx_q +: 16];
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_cfg_write: assert property (cfgWrite |=> cfgReadData == $past(cfgWriteData))
    else $error("config write not taken");
  chk_cfg_keep: assert property (!cfgWrite |=> $stable(cfgReadData))
    else $error("config changed without a write");
  chk_cfg_reset: assert property ($past(srst) |-> cfgReadData == 16'hDF48)
    else $error("config reset value wrong");
  chk_drive_follow: assert property (!cfgWrite && !$past(cfgWrite) |->
    driveHalf == cfgReadData[DRV_BIT])
    else $error("drive strength not per config");
  chk_data_enable: assert property (data_pins_oe == $past(!chipSelect_n && !outputEnable_n))
    else $error("data enable wrong");
  chk_flag_enable: assert property (readyFlag_oe == $past(!chipSelect_n))
    else $error("flag enable wrong");
  chk_async_flag: assert property (cfgReadData[MODE_BIT] && $past(cfgReadData[MODE_BIT]) |->
    readyFlag != cfgReadData[POL_BIT])
    else $error("flag ready in async mode");
  chk_latency_wait: assert property (sync && cfgReadData[TIM_BIT] && since_q >= 6'h02 &&
    since_q < 6'(latency) |-> readyFlag != cfgReadData[POL_BIT])
    else $error("flag ready before latency");
  chk_first_ready: assert property (sync && cfgReadData[TIM_BIT] && since_q == 6'(latency) &&
    $past(!outputEnable_n) |-> readyFlag == cfgReadData[POL_BIT])
    else $error("flag not ready with first word");
  chk_early_ready: assert property (sync && !cfgReadData[TIM_BIT] &&
    since_q == 6'(latency) - 6'h01 |-> readyFlag == cfgReadData[POL_BIT])
    else $error("early flag missing");
  chk_first_data: assert property (sync && since_q == 6'(latency) && $past(!outputEnable_n) |->
    data_pins_out == firstWord_q)
    else $error("first word wrong");
  cover property (sync && since_q == 6'(latency));
  cover property (cfgWrite);
  cover property ($rose(chipSelect_n) && data_pins_oe);
endmodule
bind fsb_burst_read fsb_burst_read_assertions chk (.ref_clk(ref_clk), .srst(srst),
  .cmdReset(cmdReset), .chipSelect_n(chipSelect_n), .outputEnable_n(outputEnable_n),
  .address_valid_strobe_n(address_valid_strobe_n), .address(address), .cfgWrite(cfgWrite),
  .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .lineAddr(lineAddr),
  .lineData(lineData), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
  .driveHalf(driveHalf), .readyFlag(readyFlag), .readyFlag_oe(readyFlag_oe));
`default_nettype wire

//--- testbench/fsb_burst_read_tb_top.sv
// testbench for the burst read engine: config writes, async reads, bursts
// assumes the array model returns each word as its own low address bits
`timescale 1ns/100ps
`default_nettype none
module fsb_burst_read_tb_top;
  import fsb_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cmdReset = 1'b0;
  logic chipSelect_n = 1'b1;
  logic outputEnable_n = 1'b1;
  logic address_valid_strobe_n = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic cfgWrite = 1'b0;
  logic [15:0] cfgWriteData = 16'h0000;
  logic [15:0] cfgReadData;
  logic [LINE_ADDR_W-1:0] lineAddr;
  logic [LINE_W-1:0] lineData;
  logic [WORD_W-1:0] data_pins_out;
  logic data_pins_oe;
  logic driveHalf;
  logic readyFlag;
  logic readyFlag_oe;
  int miscompares = 0;
  int checks_done = 0;
  localparam logic [15:0] CFGS [4] = '{16'h0D02, 16'h3D83, 16'h0D00, 16'h0802};
  localparam logic [25:0] ADDRS [4] = '{26'h0105, 26'h203E, 26'h030E, 26'h0403};
  localparam int COUNTS [4] = '{8, 16, 4, 8};
  localparam logic [3:0] MASKS [4] = '{4'h7, 4'hF, 4'h0, 4'h7};
  always #50 ref_clk = ~ref_clk;
  fsb_burst_read dut (.ref_clk(ref_clk), .srst(srst), .cmdReset(cmdReset),
    .chipSelect_n(chipSelect_n), .outputEnable_n(outputEnable_n),
    .address_valid_strobe_n(address_valid_strobe_n), .address(address), .cfgWrite(cfgWrite),
    .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .lineAddr(lineAddr),
    .lineData(lineData), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
    .driveHalf(driveHalf), .readyFlag(readyFlag), .readyFlag_oe(readyFlag_oe));
  fsb_array_model array (.lineAddr(lineAddr), .lineData(lineData));
  ////////////////////////////////////////////////////////////////////////////////
  // inputs always move 1 ns after the edge, so no race with the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one-cycle strobe with select low, then output enable low
  task automatic start(input logic [25:0] a);
    chipSelect_n = 1'b0;
    address_valid_strobe_n = 1'b0;
    address = a;
    step(1);
    address_valid_strobe_n = 1'b1;
    outputEnable_n = 1'b0;
  endtask
  task automatic stop();
    chipSelect_n = 1'b1;
    outputEnable_n = 1'b1;
    step(1);
  endtask
  task automatic cfg_write(input logic [15:0] v);
    cfgWrite = 1'b1;
    cfgWriteData = v;
    step(1);
    cfgWrite = 1'b0;
    step(1);
    cmp("config", v, cfgReadData);
    cmp("drive", {15'h0, v[7]}, {15'h0, driveHalf});
  endtask
  // mask 0 means continuous: linear words, line crossings cost latency minus one
  task automatic burst(input logic [25:0] a, input int n, input logic [3:0] m);
    logic [15:0] c;
    logic [15:0] w;
    int lat;
    c = cfgReadData;
    lat = c[14:11] + 2;
    start(a);
    step(lat - 1);
    for (int k = 0; k < n; k++)
    begin
      w = a[15:0] + 16'(k);
      // a wrapping burst never leaves its line, so the upper bits stay put
      if (m != 4'h0)
        w = {a[15:4], (a[3:0] & ~m) | (w[3:0] & m)};
      if (m == 4'h0 && k > 0 && w[3:0] == 4'h0)
        repeat (lat - 1)
        begin
          if (c[8])
            cmp("gap flag", {15'h0, ~c[10]}, {15'h0, readyFlag});
          step(1);
        end
      cmp("word", w, data_pins_out);
      if (c[8])
        cmp("flag", {15'h0, c[10]}, {15'h0, readyFlag});
      else if (m != 4'h0)
        cmp("early flag", {15'h0, (k < n - 1) ? c[10] : ~c[10]}, {15'h0, readyFlag});
      step(1);
    end
    if (c[8] && m != 4'h0)
      cmp("end flag", {15'h0, ~c[10]}, {15'h0, readyFlag});
    stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    step(4);
    srst = 1'b0;
    cmp("reset config", 16'hDF48, cfgReadData);
    cmp("reset drive", 16'h0000, {15'h0, driveHalf});
    start(26'h0123457);
    step(3);
    cmp("async word", 16'h3457, data_pins_out);
    cmp("async flag", 16'h0000, {15'h0, readyFlag});
    stop();
    for (int i = 0; i < 4; i++)
    begin
      cfg_write(CFGS[i]);
      burst(ADDRS[i], COUNTS[i], MASKS[i]);
    end
    cfg_write(16'h0D00);
    start(26'h0050);
    step(2);
    cmp("first word", 16'h0050, data_pins_out);
    cmp("line", 16'h0005, 16'(lineAddr));
    cmp("flag enable", 16'h0001, {15'h0, readyFlag_oe});
    stop();
    cmp("end enable", 16'h0000, {15'h0, data_pins_oe});
    cmdReset = 1'b1;
    step(1);
    cmdReset = 1'b0;
    step(1);
    cmp("config kept", 16'h0D00, cfgReadData);
    end_sim();
  end
  // watchdog against a hang
  initial
  begin
    step(20000);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
